// >>> rtl/ssa_arbiter.v
// Slave-side share arbiter for one shared slave port
`include "ssa_arb_map.vh"
`default_nettype none
module ssa_arbiter #(
  parameter N = `SSA_NUM_MASTERS,
  parameter IW = 2,
  parameter AW = `SSA_ADDR_W,
  parameter DW = `SSA_DATA_W,
  parameter BW = `SSA_BURST_W,
  parameter SW = `SSA_SHARE_W,
  parameter BURST_SLAVE = 0,
  parameter [N*SW-1:0] SHARES = {N{`SSA_SHARE_RST}},
  parameter [SW-1:0] MIN_SHARE = `SSA_MIN_SHARE_RST
) (
  input wire clk,
  input wire sys_rst,
  input wire [N-1:0] m_read,
  input wire [N-1:0] m_write,
  input wire [N*AW-1:0] m_address,
  input wire [N*DW-1:0] m_writedata,
  input wire [N*(DW/8)-1:0] m_byteenable,
  input wire [N*BW-1:0] m_burstcount,
  output wire [N-1:0] m_waitrequest,
  output wire [DW-1:0] m_readdata,
  output wire [N-1:0] m_readdatavalid,
  output wire [N-1:0] m_grant,
  output wire s_read,
  output wire s_write,
  output wire [AW-1:0] s_address,
  output wire [DW-1:0] s_writedata,
  output wire [DW/8-1:0] s_byteenable,
  output wire [BW-1:0] s_burstcount,
  input wire s_waitrequest,
  input wire [DW-1:0] s_readdata,
  input wire s_readdatavalid
);
  // ****************************************
  // Grant state
  // ****************************************
  // One instance per slave port with its own shares and minimum RL1
  localparam ST_IDLE = 2'd0;
  localparam ST_SHARE = 2'd1;
  localparam ST_BURST = 2'd2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [IW-1:0] owner_reg;
  reg [IW-1:0] owner_next;
  reg [IW-1:0] ptr_reg;
  reg [IW-1:0] ptr_next;
  reg [SW-1:0] left_reg;
  reg [SW-1:0] left_next;
  reg [BW-1:0] beats_reg;
  reg [BW-1:0] beats_next;
  reg [IW-1:0] rd_owner_reg;

  wire [N-1:0] req = m_read | m_write;
  wire pick_found;
  wire [IW-1:0] pick_idx;
  wire [BW-1:0] pick_burst;

  // Share budget for a fresh grant: larger of shares and minimum, shares alone on burst slaves
  function [SW-1:0] budget;
    input [IW-1:0] m;
    reg [SW-1:0] s;
    begin
      s = SHARES[m*SW +: SW]; // RL7 RL12
      if (BURST_SLAVE == 0 && MIN_SHARE > s) // RL15 RL16
        budget = MIN_SHARE;
      else
        budget = s;
    end
  endfunction

  // Combinational grant decision from the registered state
  reg active;
  reg [IW-1:0] cur;
  always @*
  begin
    active = 1'b0;
    cur = owner_reg;
    if (state_reg == ST_BURST)
      active = 1'b1; // RL14
    else if (state_reg == ST_SHARE && req[owner_reg] && left_reg != {SW{1'b0}})
      active = 1'b1; // RL8
    else if (pick_found)
    begin
      active = 1'b1; // RL3 RL11
      cur = pick_idx;
    end
  end

  ssa_rr_pick #(
    .N(N),
    .IW(IW)
  ) u_pick (
    .req(req),
    .ptr(ptr_reg),
    .found(pick_found),
    .idx(pick_idx)
  );

  ssa_mux #(
    .N(N),
    .IW(IW),
    .W(BW)
  ) u_mux_burst (
    .bus_in(m_burstcount),
    .sel(cur),
    .bus_out(pick_burst)
  );

  // ****************************************
  // Next state
  // ****************************************
  wire fresh = active && !(state_reg != ST_IDLE && cur == owner_reg && state_reg != ST_IDLE
    && !(state_reg == ST_SHARE && (!req[owner_reg] || left_reg == {SW{1'b0}})));
  wire xfer_done = active && req[cur] && !s_waitrequest;

  always @*
  begin
    state_next = state_reg;
    owner_next = owner_reg;
    ptr_next = ptr_reg;
    left_next = left_reg;
    beats_next = beats_reg;
    if (!active)
      state_next = ST_IDLE;
    else if (state_reg == ST_BURST)
    begin
      if (xfer_done && m_write[cur])
        beats_next = beats_reg - 1'b1;
      if (s_readdatavalid && rd_owner_reg == cur && !m_write[cur])
        beats_next = beats_reg - 1'b1;
      if (beats_next == {BW{1'b0}})
      begin
        state_next = ST_IDLE; // RL14
        ptr_next = cur + 1'b1; // RL9
      end
    end
    else
    begin
      if (fresh)
      begin
        owner_next = cur;
        left_next = budget(cur); // RL12
      end
      if (xfer_done)
      begin
        if (BURST_SLAVE != 0 && pick_burst > {{(BW-1){1'b0}}, 1'b1})
        begin
          state_next = ST_BURST; // RL13 RL14 RL16
          beats_next = m_read[cur] ? pick_burst : pick_burst - 1'b1;
        end
        else
        begin
          left_next = (fresh ? budget(cur) : left_reg) - 1'b1; // RL7
          state_next = ST_SHARE;
          if (left_next == {SW{1'b0}})
            ptr_next = cur + 1'b1; // RL8 RL9
        end
      end
      else if (fresh)
        state_next = ST_SHARE;
    end
    if (state_reg == ST_SHARE && !req[owner_reg])
      ptr_next = owner_reg + 1'b1; // RL11
  end

  // Registered state, reset to lowest master and idle
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE; // RL17
      owner_reg <= {IW{1'b0}};
      ptr_reg <= {IW{1'b0}}; // RL17
      left_reg <= `SSA_SHARE_RST;
      beats_reg <= {BW{1'b0}};
      rd_owner_reg <= {IW{1'b0}};
    end
    else
    begin
      state_reg <= state_next;
      owner_reg <= owner_next;
      ptr_reg <= ptr_next;
      left_reg <= left_next;
      beats_reg <= beats_next;
      if (xfer_done && m_read[cur])
        rd_owner_reg <= cur;
    end
  end

  // ****************************************
  // Datapath and wait generation
  // ****************************************
  ssa_mux #(.N(N), .IW(IW), .W(AW)) u_mux_addr (
    .bus_in(m_address),
    .sel(cur),
    .bus_out(s_address)
  );
  ssa_mux #(.N(N), .IW(IW), .W(DW)) u_mux_wdata (
    .bus_in(m_writedata),
    .sel(cur),
    .bus_out(s_writedata)
  );
  ssa_mux #(.N(N), .IW(IW), .W(DW/8)) u_mux_be (
    .bus_in(m_byteenable),
    .sel(cur),
    .bus_out(s_byteenable)
  );

  assign s_burstcount = pick_burst;
  assign s_read = active & m_read[cur]; // RL6
  assign s_write = active & m_write[cur]; // RL6
  assign m_readdata = s_readdata; // RL6

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_port
      // Wait only when requesting without grant, or slave stalls
      assign m_grant[g] = active && cur == g; // RL3
      assign m_waitrequest[g] = req[g] & (~m_grant[g] | s_waitrequest); // RL2 RL4 RL5
      assign m_readdatavalid[g] = s_readdatavalid && rd_owner_reg == g; // RL6
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/ssa_mux.v
// Path multiplexer steering one master's signals onto the slave
`default_nettype none
module ssa_mux #(
  parameter N = 4,
  parameter IW = 2,
  parameter W = 32
) (
  input wire [N*W-1:0] bus_in,
  input wire [IW-1:0] sel,
  output wire [W-1:0] bus_out
);
  // Plain indexed part-select keeps the mux flat
  assign bus_out = bus_in[sel*W +: W]; // RL6
endmodule
`default_nettype wire

// >>> rtl/ssa_rr_pick.v
// Round-robin picker: first requester at or after the pointer
`default_nettype none
module ssa_rr_pick #(
  parameter N = 4,
  parameter IW = 2
) (
  input wire [N-1:0] req,
  input wire [IW-1:0] ptr,
  output reg found,
  output reg [IW-1:0] idx
);
  integer k;
  integer t;
  reg [IW:0] cand;
  // Scan backwards so the nearest requester from the pointer wins
  always @*
  begin
    found = 1'b0;
    idx = {IW{1'b0}};
    cand = {(IW+1){1'b0}};
    t = 0;
    for (k = N - 1; k >= 0; k = k - 1)
    begin
      // Integer arithmetic, then cut to one bit wider than the index on purpose
      t = (ptr + k) % N;
      cand = t[IW:0];
      if (req[cand[IW-1:0]]) // RL10
      begin
        found = 1'b1;
        idx = cand[IW-1:0]; // RL9
      end
    end
  end
endmodule
`default_nettype wire

// >>> shared/ssa_arb_map.vh
// Constants for the slave-side share arbiter
// Operation
// (RL1) One arbiter per slave, own parameters
// (RL2) Stall only on same-cycle contention
// (RL3) Each cycle pick at most one master
// (RL4) Other requesters are held waiting
// (RL5) Arbiter generates wait: request without grant
// (RL6) Mux granted master paths, return responses
// (RL7) Integer share count, one per transfer
// (RL8) Run of share-count transfers, then rotate
// (RL9) Rotate grants round-robin
// (RL10) Only requesting masters join arbitration
// (RL11) Request gap forfeits remaining shares
// (RL12) Regrant restores full share count
// (RL13) Master gives burst count at start
// (RL14) Burst locks grant until complete
// (RL15) Grant at least max(minimum, shares)
// (RL16) Minimum share ignored on burst slaves
// (RL17) Reset: pointer zero, counters loaded, idle
`ifndef SSA_ARB_MAP_VH
`define SSA_ARB_MAP_VH
`define SSA_NUM_MASTERS 4
`define SSA_ADDR_W 32
`define SSA_DATA_W 32
`define SSA_BURST_W 8
`define SSA_SHARE_W 8
`define SSA_SHARE_RST 8'h01
`define SSA_MIN_SHARE_RST 8'h01
`define SSA_PTR_RST 0
`endif

// >>> testbench/ssa_arbiter_props.sv
// Checker for grant, wait and steering of the share arbiter
`default_nettype none
module ssa_arbiter_props #(parameter N = 2) (
  input wire clk,
  input wire sys_rst,
  input wire [N-1:0] m_read,
  input wire [N-1:0] m_write,
  input wire [N-1:0] m_waitrequest,
  input wire [N-1:0] m_grant,
  input wire s_read,
  input wire s_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // Any request kind counts as contention
  wire [N-1:0] r = m_read | m_write;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  property p_one; $onehot0(m_grant); endproperty
  a_one: assert property (p_one) else $error("more than one grant");
  property p_wait; m_waitrequest == (r & (~m_grant | {N{s_waitrequest}})); endproperty
  a_wait: assert property (p_wait) else $error("wait mismatch");
  property p_free; $onehot(r) && !s_waitrequest |-> m_waitrequest == 0; endproperty
  a_free: assert property (p_free) else $error("lone master stalled");
  property p_only; (m_grant & ~r) == 0; endproperty
  a_only: assert property (p_only) else $error("idle master granted");
  property p_pick; r != 0 |-> m_grant != 0; endproperty
  a_pick: assert property (p_pick) else $error("request without grant");
  property p_mux; s_read == |(m_grant & m_read); endproperty
  a_mux: assert property (p_mux) else $error("read not steered");
  // A stalled transfer uses no share, so the owner keeps the grant
  property p_hold;
    (m_grant & r) != 0 && s_waitrequest ##1 ($past(m_grant) & r) != 0
      |-> m_grant == $past(m_grant);
  endproperty
  a_hold: assert property (p_hold) else $error("grant lost on stall");
  property p_rst; disable iff (1'b0) sys_rst && r != 0 |-> m_grant == (r & -r); endproperty
  a_rst: assert property (p_rst) else $error("reset grant wrong");
  c_both: cover property (&r);
  c_stall: cover property (s_waitrequest && (m_grant & r) != 0);
  c_drop: cover property (&r ##1 !(&r) && r != 0);
endmodule
bind ssa_arbiter ssa_arbiter_props #(.N(N)) ssa_arbiter_props_i (.clk(clk),
  .sys_rst(sys_rst), .m_read(m_read), .m_write(m_write), .m_waitrequest(m_waitrequest),
  .m_grant(m_grant), .s_read(s_read), .s_waitrequest(s_waitrequest));
`default_nettype wire

// >>> testbench/ssa_arbiter_tb_top.sv
// Bench for the share arbiter: two masters with shares 3 and 4
`default_nettype none
module ssa_arbiter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic stall = 1'b0;
  logic [1:0] m_read = 2'h0;
  logic [1:0] pv = 2'h0;
  logic [7:0] pa = 8'h00;
  // Per-master address, write data and byte enables with distinct values so steering is visible; burst counts are both 1
  logic [1:0] m_write = 2'h0;
  logic [15:0] m_addr = 16'h2110;
  logic [15:0] m_wdata = 16'hB4C3;
  logic [1:0] m_be = 2'h1;
  logic [7:0] m_bc = 8'h11;
  wire s_write;
  wire [7:0] s_writedata;
  wire [0:0] s_byteenable;
  wire [3:0] s_burstcount;
  wire [1:0] m_waitrequest, m_readdatavalid, m_grant;
  wire [7:0] m_readdata, s_address, s_readdata;
  wire s_read, s_waitrequest, s_readdatavalid;
  int fails = 0;
  int check_count = 0;
  // Rows hold request pair, stall and expected grant
  logic [4:0] rows [22] = '{5'h19, 5'h19, 5'h19, 5'h1A, 5'h1A, 5'h1A, 5'h1A, 5'h19,
    5'h1D, 5'h19, 5'h19, 5'h1A, 5'h09, 5'h19, 5'h19, 5'h1A, 5'h1A, 5'h1A, 5'h1A,
    5'h12, 5'h00, 5'h16};
  always #50 clk = ~clk;
  // Single beats only, so no burst lock is taken
  ssa_arbiter #(.N(2), .IW(1), .AW(8), .DW(8), .BW(4), .SHARES(16'h0403)) ssa_arbiter_i (
    .clk(clk), .sys_rst(sys_rst), .m_read(m_read), .m_write(m_write),
    .m_address(m_addr), .m_writedata(m_wdata), .m_byteenable(m_be),
    .m_burstcount(m_bc),
    .m_waitrequest(m_waitrequest), .m_readdata(m_readdata),
    .m_readdatavalid(m_readdatavalid), .m_grant(m_grant), .s_read(s_read),
    .s_write(s_write), .s_address(s_address), .s_writedata(s_writedata),
    .s_byteenable(s_byteenable), .s_burstcount(s_burstcount),
    .s_waitrequest(s_waitrequest), .s_readdata(s_readdata),
    .s_readdatavalid(s_readdatavalid));
  ssa_slave_model ssa_slave_model_i (.clk(clk), .s_read(s_read), .s_address(s_address),
    .stall(stall), .s_waitrequest(s_waitrequest), .s_readdata(s_readdata),
    .s_readdatavalid(s_readdatavalid));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read data returns one cycle after the accepted beat
  task step(input logic [1:0] r, input logic st, input logic [1:0] e);
    @(posedge clk);
    m_read <= r;
    stall <= st;
    #10;
    chk(m_grant, e);
    chk(m_waitrequest, r & (~e | {2{st}}));
    chk(s_write, 1'b0);
    if (e != 0)
      chk(s_address, e[1] ? 8'h21 : 8'h10);
    if (e != 0)
      chk(s_writedata, e[1] ? 8'hB4 : 8'hC3);
    if (e != 0)
      chk(s_byteenable, e[1] ? 8'h00 : 8'h01);
    if (e != 0)
      chk(s_burstcount, 8'h01);
    chk(m_readdatavalid, pv);
    if (pv != 0)
      chk(m_readdata, pa ^ 8'h5A);
    pv = e & r & {2{!st}};
    pa = e[1] ? 8'h21 : 8'h10;
  endtask
  initial
  begin
    @(posedge clk);
    m_read <= 2'h2;
    repeat (8) @(posedge clk);
    #10;
    chk(m_grant, 2'h2);
    @(posedge clk);
    m_read <= 2'h0;
    @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 22; i++)
      step(rows[i][4:3], rows[i][2], rows[i][1:0]);
    step(2'h3, 1'b0, 2'h2);
    // Mid-run reset with the slave stalled so no stray read returns
    @(posedge clk);
    sys_rst <= 1'b1;
    stall <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    pv = 2'h0;
    step(2'h3, 1'b0, 2'h1);
    end_sim;
  end
  // Watchdog well beyond the 37 cycles the tests need
  initial
  begin
    #20000;
    fails++;
    end_sim;
  end
endmodule
`default_nettype wire

// >>> testbench/ssa_slave_model.sv
// Slave model for the shared port: stalls on command, answers reads next cycle
`default_nettype none
module ssa_slave_model (
  input wire logic clk,
  input wire logic s_read,
  input wire logic [7:0] s_address,
  input wire logic stall,
  output logic s_waitrequest,
  output logic [7:0] s_readdata,
  output logic s_readdatavalid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial s_readdata = 8'h00;
  initial s_readdatavalid = 1'b0;
  assign s_waitrequest = stall;
  // Idle data flips each cycle so a stale value never passes
  always @(posedge clk)
  begin
    s_readdatavalid <= s_read & !stall;
    s_readdata <= (s_read & !stall) ? s_address ^ 8'h5A : ~s_readdata;
  end
endmodule
`default_nettype wire
